// [design/lwx_defs.svh]
`ifndef LWX_DEFS_SVH
`define LWX_DEFS_SVH

// ==========================================================
// word layout
`define LWX_WORD_W      26
`define LWX_INFO_W      24
`define LWX_START_POS   25
`define LWX_CTRL_POS    24
`define LWX_CNT_W       5
`define LWX_LAST_BIT    5'd25

// ==========================================================
// timing
`define LWX_CLK_HZ      250000000
`define LWX_BIT_RATE    1400
`define LWX_STEPS       3
`define LWX_TICK_W      16
`define LWX_STEP_MID    2'd1
`define LWX_STEP_LAST   2'd2

// ==========================================================
// register map
`define LWX_ADDR_W      12
`define LWX_ADDR_CTRL   12'h000
`define LWX_ADDR_LOAD   12'h004
`define LWX_ADDR_SCAN0  12'h008
`define LWX_ADDR_SCAN1  12'h00c
`define LWX_ADDR_STAT   12'h010
`define LWX_CTRL_START  0
`define LWX_CTRL_KCLR   1
`define LWX_ST_KEY      0
`define LWX_ST_BUSY     1
`define LWX_ST_REFUSED  2
`define LWX_ROW_W       16
`define LWX_CONS_W      4
`define LWX_HI_W        10
`define LWX_ZERO32      32'h0000_0000

`endif

// [design/lwx_pkg.sv]
package lwx_pkg;
    // ======================================================
    // types
    typedef logic [25:0] lwx_word_t;
    typedef enum logic [1:0] {
        LWX_IDLE,
        LWX_PEND,
        LWX_ACTIVE
    } lwx_state_t;
endpackage : lwx_pkg

// [design/lwx_shift_reg.sv]
`timescale 1ns/1ns
`default_nettype none
`include "lwx_defs.svh"

module lwx_shift_reg (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            load,
    input  wire lwx_pkg::lwx_word_t load_word,
    input  wire logic            shift,
    input  wire logic            sin,
    output lwx_pkg::lwx_word_t   q
);
    import lwx_pkg::*;

    // ======================================================
    // shared word store, parallel load or shift toward msb
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else if (load) begin
            q <= load_word;
        end else if (shift) begin
            q <= {q[`LWX_WORD_W-2:0], sin};
        end
    end
endmodule : lwx_shift_reg

`default_nettype wire

// [design/lwx_link.sv]
// Functional notes
// RQ1 - word is 26 bits: start, control, 24 info
// RQ2 - receiver starts taking bits at leading one
// RQ3 - one 26-bit register serialises and deserialises
// RQ4 - register holds 24 bus data bits for sending
// RQ5 - register keeps received key data for reading
// RQ6 - far register holds key data, takes lamp data
// RQ7 - office times loop; either end may request
// RQ8 - idle line sends continuous spaces
// RQ9 - transfer shifts register out, mark first
// RQ10 - on start mark receiver shifts with stream
// RQ11 - transfer swaps both registers at once
// RQ12 - empty end sends all-zero word
// RQ13 - 1400 bits per second each direction
// RQ14 - register read as two 16-point rows
// RQ15 - 26 word points, 4 console, 2 spare
// RQ16 - processor reads rows when key flag set
// RQ17 - key flag set when key word received
// RQ18 - processor defers lamp load while key held
// RQ19 - lamp load only under distributor enable
// RQ20 - two one-way links form closed loop
// RQ21 - far end decodes lamp words into lamps
// RQ22 - bit counter marks end of transfer
// RQ23 - processor checks busy and waiting before load
// RQ24 - space one low half cycle, mark three high
// RQ25 - control follows start, info msb first
`timescale 1ns/1ns
`default_nettype none
`include "lwx_defs.svh"

module lwx_link #(
    parameter int TICK_CYCLES = `LWX_CLK_HZ / (`LWX_BIT_RATE * `LWX_STEPS)
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`LWX_ADDR_W-1:0]    paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      pulse_distributor_enable,
    input  wire logic                      remote_request,
    input  wire logic                      rx_line,
    input  wire logic [`LWX_CONS_W-1:0]    console_state,
    output logic                           tx_line,
    output logic                           tx_tone,
    output logic                           key_present_flag,
    output logic                           busy
);
    import lwx_pkg::*;

    localparam logic [`LWX_TICK_W-1:0] TICK_LAST =
        `LWX_TICK_W'(TICK_CYCLES - 1);

    // ======================================================
    // declarations
    lwx_state_t               state_q;
    logic [`LWX_TICK_W-1:0]   tick_cnt_q;
    logic [1:0]               step_q;
    logic                     tick;
    logic                     bit_edge;
    logic                     mid_bit;
    logic [`LWX_CNT_W-1:0]    bit_cnt_q;
    logic                     rx_started_q;
    logic                     rx_bit_q;
    logic                     load_refused_q;
    logic                     shift_en;
    logic                     load_en;
    logic                     rx_in;
    lwx_word_t                load_word;
    lwx_word_t                word;
    logic                     start_ok;
    logic                     done;
    logic                     apb_access;
    logic                     apb_fire;
    logic                     wr_fire;
    logic                     wr_ctrl;
    logic                     wr_load;
    logic                     wr_stat;
    logic                     cpu_start;
    logic                     key_clr;
    logic                     pde_m_q, pde_s_q;
    logic                     req_m_q, req_s_q;
    logic                     rx_m_q, rx_s_q;
    logic [`LWX_CONS_W-1:0]   cons_m_q, cons_s_q;

    // ======================================================
    // address decode helpers
    function automatic logic addr_ok(input logic [`LWX_ADDR_W-1:0] a);
        case (a)
            `LWX_ADDR_CTRL,
            `LWX_ADDR_LOAD,
            `LWX_ADDR_SCAN0,
            `LWX_ADDR_SCAN1,
            `LWX_ADDR_STAT: addr_ok = 1'b1;
            default:        addr_ok = 1'b0;
        endcase
    endfunction : addr_ok

    function automatic logic hit(input logic [`LWX_ADDR_W-1:0] a,
                                 input logic [`LWX_ADDR_W-1:0] b);
        hit = (a == b);
    endfunction : hit

    // ======================================================
    // two-stage synchronisers for pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pde_m_q  <= 1'b0;
            pde_s_q  <= 1'b0;
            req_m_q  <= 1'b0;
            req_s_q  <= 1'b0;
            rx_m_q   <= 1'b0;
            rx_s_q   <= 1'b0;
            cons_m_q <= '0;
            cons_s_q <= '0;
        end else begin
            pde_m_q  <= pulse_distributor_enable;
            pde_s_q  <= pde_m_q;
            req_m_q  <= remote_request;
            req_s_q  <= req_m_q;
            rx_m_q   <= rx_line;
            rx_s_q   <= rx_m_q;
            cons_m_q <= console_state;
            cons_s_q <= cons_m_q;
        end
    end

    // ======================================================
    // apb slave: one wait state, answer from registers
    assign apb_access = psel & penable;
    assign apb_fire   = apb_access & pready;
    assign wr_fire    = apb_fire & pwrite;
    assign wr_ctrl    = wr_fire & hit(paddr, `LWX_ADDR_CTRL);
    assign wr_load    = wr_fire & hit(paddr, `LWX_ADDR_LOAD);
    assign wr_stat    = wr_fire & hit(paddr, `LWX_ADDR_STAT);
    assign cpu_start  = wr_ctrl & pwdata[`LWX_CTRL_START];
    assign key_clr    = wr_ctrl & pwdata[`LWX_CTRL_KCLR];

    // pready pulses one cycle into each access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= apb_access & ~pready;
        end
    end

    // read data and error captured with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `LWX_ZERO32;
            pslverr <= 1'b0;
        end else if (apb_access & ~pready) begin
            pslverr <= ~addr_ok(paddr);
            prdata  <= `LWX_ZERO32;
            if (!pwrite) begin
                case (paddr)
                    // low row: word bits 15..0
                    `LWX_ADDR_SCAN0: begin
                        prdata[`LWX_ROW_W-1:0] <= word[`LWX_ROW_W-1:0]; // RQ14
                    end
                    // high row: word 25..16, console state, spares
                    `LWX_ADDR_SCAN1: begin
                        prdata[`LWX_HI_W-1:0] <=
                            word[`LWX_WORD_W-1:`LWX_ROW_W]; // RQ15
                        prdata[`LWX_HI_W+`LWX_CONS_W-1:`LWX_HI_W] <=
                            cons_s_q; // RQ15
                    end
                    `LWX_ADDR_STAT: begin
                        prdata[`LWX_ST_KEY]     <= key_present_flag;
                        prdata[`LWX_ST_BUSY]    <= busy;
                        prdata[`LWX_ST_REFUSED] <= load_refused_q;
                    end
                    default: begin
                        prdata <= `LWX_ZERO32;
                    end
                endcase
            end
        end
    end

    // ======================================================
    // lamp word load, gated by distributor enable and idle
    assign load_en = wr_load & pde_s_q & (state_q == LWX_IDLE); // RQ19
    // start mark, control bit, then info msb first
    assign load_word = {1'b1, pwdata[`LWX_INFO_W],
                        pwdata[`LWX_INFO_W-1:0]}; // RQ25 RQ4 RQ1

    // refused loads leave a sticky flag, set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_refused_q <= 1'b0;
        end else if (wr_load & ~load_en) begin
            load_refused_q <= 1'b1; // RQ19
        end else if (wr_stat & pwdata[`LWX_ST_REFUSED]) begin
            load_refused_q <= 1'b0;
        end
    end

    // ======================================================
    // bit timing: three steps per bit, 1400 bit/s
    assign tick     = (tick_cnt_q == TICK_LAST);
    assign bit_edge = tick & (step_q == `LWX_STEP_LAST);
    assign mid_bit  = tick & (step_q == `LWX_STEP_MID);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0; // RQ13
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    // step within a bit interval
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_q <= '0;
        end else if (bit_edge) begin
            step_q <= '0; // RQ13
        end else if (tick) begin
            step_q <= step_q + 1'b1;
        end
    end

    // ======================================================
    // transfer sequencing, office owns the loop timing
    assign start_ok = cpu_start | req_s_q;
    assign done     = bit_edge & (state_q == LWX_ACTIVE) &
                      (bit_cnt_q == `LWX_LAST_BIT);
    assign shift_en = bit_edge & (state_q == LWX_ACTIVE); // RQ11 RQ3

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= LWX_IDLE;
        end else begin
            case (state_q)
                // request from processor or far console
                LWX_IDLE: begin
                    if (start_ok) begin
                        state_q <= LWX_PEND; // RQ7
                    end
                end
                // wait for the next bit boundary
                LWX_PEND: begin
                    if (bit_edge) begin
                        state_q <= LWX_ACTIVE; // RQ9
                    end
                end
                LWX_ACTIVE: begin
                    if (done) begin
                        state_q <= LWX_IDLE; // RQ22
                    end
                end
                default: begin
                    state_q <= LWX_IDLE;
                end
            endcase
        end
    end

    // bit counter ends the word after 26 slots
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_q <= '0;
        end else if (state_q != LWX_ACTIVE) begin
            bit_cnt_q <= '0;
        end else if (bit_edge) begin
            bit_cnt_q <= bit_cnt_q + 1'b1; // RQ22
        end
    end

    // ======================================================
    // receive: sample mid bit, accept from the start mark
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_bit_q <= 1'b0;
        end else if (mid_bit) begin
            rx_bit_q <= rx_s_q;
        end
    end

    // receiver leaves idle on the first mark of a transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_started_q <= 1'b0;
        end else if (state_q != LWX_ACTIVE) begin
            rx_started_q <= 1'b0;
        end else if (mid_bit & rx_s_q) begin
            rx_started_q <= 1'b1; // RQ2 RQ10
        end
    end

    // spaces before the start mark are shifted in as zeros
    assign rx_in = rx_bit_q & (rx_started_q | rx_s_q); // RQ2 RQ10 RQ12

    lwx_shift_reg u_word (
        .pclk      (pclk),
        .presetn   (presetn),
        .load      (load_en),
        .load_word (load_word),
        .shift     (shift_en),
        .sin       (rx_in),
        .q         (word)
    );

    // ======================================================
    // key present flag, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_present_flag <= 1'b0;
        end else if (done & rx_started_q) begin
            key_present_flag <= 1'b1; // RQ17 RQ5
        end else if (key_clr) begin
            key_present_flag <= 1'b0;
        end
    end

    // busy from request until the last bit has gone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_q != LWX_IDLE) | start_ok;
        end
    end

    // ======================================================
    // transmit data level: mark first, spaces when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_line <= 1'b0;
        end else if (done) begin
            tx_line <= 1'b0; // RQ8
        end else if ((state_q == LWX_PEND) & bit_edge) begin
            tx_line <= 1'b1; // RQ9
        end else if (shift_en) begin
            tx_line <= word[`LWX_CTRL_POS]; // RQ9 RQ25
        end
    end

    // tone: space one half cycle, mark three per bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_tone <= 1'b0;
        end else if (bit_edge | (tick & tx_line)) begin
            tx_tone <= ~tx_tone; // RQ24 RQ20
        end
    end
endmodule : lwx_link

`default_nettype wire

// [test/lwx_link_props.sv]
`timescale 1ns/1ns
`default_nettype none
`include "lwx_defs.svh"

module lwx_link_props #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`LWX_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   tx_line,
    input wire logic                   tx_tone,
    input wire logic                   key_present_flag,
    input wire logic                   busy
);
    // ==========================================================
    // tone edge spacing
    logic [17:0] gap_q;
    logic        tone_q;
    logic        seen_q;

    // cycles since the last tone edge, armed only inside a frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q  <= 18'h0;
            tone_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            tone_q <= tx_tone;
            gap_q  <= (tx_tone != tone_q) ? 18'h1 : gap_q + 18'h1;
            seen_q <= busy && (seen_q || tx_tone != tone_q);
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // bus answers and link timing
    ready_timing_a: assert property ($rose(psel && penable) |=> pready)
        else $error("pready not one cycle after access");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    bad_addr_a: assert property (pready && paddr > 12'h010 |->
        pslverr && prdata == 32'h0) else $error("unmapped not refused");
    good_addr_a: assert property (pready && paddr <= 12'h010 &&
        paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    spare_zero_a: assert property (pready && !pwrite &&
        paddr == 12'h00c |-> prdata[31:14] == 18'h0)
        else $error("spare points not zero");
    idle_space_a: assert property (!busy |-> !tx_line)
        else $error("mark sent while idle");
    key_end_a: assert property ($rose(key_present_flag) |->
        $past(busy) ##[0:2] !busy) else $error("key flag off frame end");
    flag_clear_a: assert property (pready && pwrite && !busy &&
        paddr == 12'h000 && pwdata[1] |=> !key_present_flag)
        else $error("key flag not cleared");
    tone_step_a: assert property (seen_q && tx_tone != tone_q |->
        gap_q == TICK_CYCLES || gap_q == 3 * TICK_CYCLES)
        else $error("tone edge off step grid");
endmodule : lwx_link_props

bind lwx_link lwx_link_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_line(tx_line),
    .tx_tone(tx_tone), .key_present_flag(key_present_flag), .busy(busy)
);
`default_nettype wire

// [test/lwx_far_console.sv]
`timescale 1ns/1ns
`default_nettype none

module lwx_far_console #(
    parameter int BIT_CLK = 12
) (
    input  wire logic               pclk,
    input  wire logic               tx_line,
    input  wire logic               key_load,
    input  wire lwx_pkg::lwx_word_t key_word,
    output var logic                rx_line,
    output var logic                remote_request,
    output lwx_pkg::lwx_word_t      lamp_word
);
    import lwx_pkg::*;
    // ==========================================================
    // far register and bit timing
    lwx_word_t word_q = '0;
    int        cnt_q  = 0;
    int        bit_q  = 0;
    logic      act_q  = 1'b0;

    initial begin
        rx_line        = 1'b0;
        remote_request = 1'b0;
        lamp_word      = '0;
    end

    // swap words in step with the office, spaces while idle
    always @(posedge pclk) begin
        if (key_load) begin
            word_q         <= key_word;
            remote_request <= 1'b1;
        end
        if (!act_q) begin
            rx_line <= 1'b0;
            if (tx_line) begin
                act_q          <= 1'b1;
                cnt_q          <= 1;
                bit_q          <= 0;
                rx_line        <= word_q[25];
                remote_request <= 1'b0;
            end
        end else begin
            cnt_q <= (cnt_q == BIT_CLK) ? 1 : cnt_q + 1;
            if (cnt_q == BIT_CLK / 2)
                word_q <= {word_q[24:0], tx_line};
            if (cnt_q == BIT_CLK && bit_q == 25) begin
                act_q     <= 1'b0;
                rx_line   <= 1'b0;
                lamp_word <= word_q;
                word_q    <= '0;
            end else if (cnt_q == BIT_CLK) begin
                bit_q   <= bit_q + 1;
                rx_line <= word_q[25];
            end
        end
    end
endmodule : lwx_far_console
`default_nettype wire

// [test/tb_loop_word_exchange_link.sv]
`timescale 1ns/1ns
`default_nettype none
`include "lwx_defs.svh"

module tb_loop_word_exchange_link;
    import lwx_pkg::*;
    localparam int TICK = 4;
    localparam int BIT  = 3 * TICK;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pulse_distributor_enable = 1'b1;
    logic        remote_request;
    logic        rx_line;
    logic [3:0]  console_state = 4'h9;
    logic        tx_line;
    logic        tx_tone;
    logic        key_present_flag;
    logic        busy;
    logic        key_load = 1'b0;
    lwx_word_t   key_word = '0;
    lwx_word_t   lamp_word;
    logic        last_err;
    logic        busy_q = 1'b0;
    int          mark_n = 0;
    int          n_errors = 0;
    int          check_count = 0;

    lwx_link #(.TICK_CYCLES(TICK)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .pulse_distributor_enable(pulse_distributor_enable),
        .remote_request(remote_request), .rx_line(rx_line),
        .console_state(console_state), .tx_line(tx_line),
        .tx_tone(tx_tone), .key_present_flag(key_present_flag),
        .busy(busy));

    lwx_far_console #(.BIT_CLK(BIT)) far (
        .pclk(pclk), .tx_line(tx_line), .key_load(key_load),
        .key_word(key_word), .rx_line(rx_line),
        .remote_request(remote_request), .lamp_word(lamp_word));

    always #2 pclk = ~pclk;

    // cycles from the first start mark seen until busy drops
    always @(posedge pclk) begin
        busy_q <= busy;
        if (busy && !busy_q)
            mark_n <= 0;
        else if (busy && (tx_line || mark_n != 0))
            mark_n <= mark_n + 1;
    end

    // ==========================================================
    // shared tasks
    task automatic final_report();
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", {31'h0, pready}, 32'h1);
        rd       = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        apb(1'b1, a, d, rd);
    endtask : wr

    task automatic rdc(input string nm, input logic [11:0] a,
                       input logic [31:0] exp);
        logic [31:0] rd;
        apb(1'b0, a, 32'h0, rd);
        chk(nm, rd, exp);
    endtask : rdc

    // waits for a whole frame and checks its length
    task automatic wait_frame();
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        chk("busy_rise", {31'h0, busy}, 32'h1);
        n = 0;
        while (busy !== 1'b0 && n < 30 * BIT) begin
            @(posedge pclk);
            n++;
        end
        chk("frame_len", mark_n, 26 * BIT + 1);
        repeat (3) @(posedge pclk);
    endtask : wait_frame

    // ==========================================================
    // scenarios
    task automatic t_reset_regs();
        rdc("status", `LWX_ADDR_STAT, 32'h0);
        rdc("scan0", `LWX_ADDR_SCAN0, 32'h0);
        rdc("scan1", `LWX_ADDR_SCAN1, 32'h2400);
        rdc("ctrl", `LWX_ADDR_CTRL, 32'h0);
        rdc("unmapped", 12'h020, 32'h0);
        chk("slverr", {31'h0, last_err}, 32'h1);
    endtask : t_reset_regs

    task automatic t_refused();
        pulse_distributor_enable <= 1'b0;
        repeat (4) @(posedge pclk);
        wr(`LWX_ADDR_LOAD, 32'h01ab_cdef);
        rdc("st_refused", `LWX_ADDR_STAT, 32'h4);
        rdc("scan0_kept", `LWX_ADDR_SCAN0, 32'h0);
        wr(`LWX_ADDR_STAT, 32'h4);
        rdc("st_cleared", `LWX_ADDR_STAT, 32'h0);
        pulse_distributor_enable <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : t_refused

    // office sends lamp word, far end empty, load while busy refused
    task automatic t_lamp();
        rdc("st_idle", `LWX_ADDR_STAT, 32'h0);
        wr(`LWX_ADDR_LOAD, 32'h015a_c396);
        rdc("scan0_lamp", `LWX_ADDR_SCAN0, 32'h0000_c396);
        rdc("scan1_lamp", `LWX_ADDR_SCAN1, 32'h0000_275a);
        wr(`LWX_ADDR_CTRL, 32'h1);
        rdc("st_busy", `LWX_ADDR_STAT, 32'h2);
        wr(`LWX_ADDR_LOAD, 32'h00ff_ffff);
        wait_frame();
        chk("lamp_word", {6'h0, lamp_word}, 32'h035a_c396);
        rdc("st_lamp", `LWX_ADDR_STAT, 32'h4);
        rdc("scan0_zero", `LWX_ADDR_SCAN0, 32'h0);
        wr(`LWX_ADDR_STAT, 32'h4);
    endtask : t_lamp

    // far end asks, both ends hold words and swap them
    task automatic t_remote_swap();
        console_state <= 4'h6;
        wr(`LWX_ADDR_LOAD, 32'h000f_1e2d);
        key_word <= 26'h39b_8a7c;
        key_load <= 1'b1;
        @(posedge pclk);
        key_load <= 1'b0;
        wait_frame();
        chk("lamp_swap", {6'h0, lamp_word}, 32'h020f_1e2d);
        rdc("st_key", `LWX_ADDR_STAT, 32'h1);
        chk("key_pin", {31'h0, key_present_flag}, 32'h1);
        rdc("scan0_key", `LWX_ADDR_SCAN0, 32'h0000_8a7c);
        rdc("scan1_key", `LWX_ADDR_SCAN1, 32'h0000_1b9b);
        wr(`LWX_ADDR_CTRL, 32'h2);
        rdc("st_kclr", `LWX_ADDR_STAT, 32'h0);
    endtask : t_remote_swap

    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_reset_regs();
        t_refused();
        t_lamp();
        t_remote_swap();
        final_report();
    end

    initial begin
        repeat (8000) @(posedge pclk);
        n_errors++;
        final_report();
    end
endmodule : tb_loop_word_exchange_link
`default_nettype wire
